/* rtl/intc_consts.svh */
// Constants for the prioritized interrupt controller: SFR addresses,
// bit positions, reset values, vectors and response timing.
// Assumes inclusion by bare name from the rtl folder.
`ifndef INTC_CONSTS_SVH
`define INTC_CONSTS_SVH

// SFR addresses
`define INTC_ADDR_IEN0 8'hA8
`define INTC_ADDR_IEN1 8'hB8
`define INTC_ADDR_IEN2 8'h9A
`define INTC_ADDR_PRIO_LOW 8'hA9
`define INTC_ADDR_PRIO_HIGH 8'hB9
`define INTC_ADDR_EXT_FLAGS 8'hC0
`define INTC_ADDR_WDI 8'hE8

// Enable register 0 fields
`define INTC_IEN0_GLOBAL 7
`define INTC_IEN0_SER0 4
`define INTC_IEN0_TMR1 3
`define INTC_IEN0_EXT1 2
`define INTC_IEN0_TMR0 1
`define INTC_IEN0_EXT0 0
`define INTC_IEN0_MASK 8'h9F
// Enable register 1: ext2..ext6 at bits 1..5
`define INTC_IEN1_EXT2 1
`define INTC_IEN1_MASK 8'h3E
// Enable register 2
`define INTC_IEN2_SER1 0
`define INTC_IEN2_MASK 8'h01

// Low priority register: bits 5..0 groups, bit 6 watchdog select
`define INTC_PRIO_LOW_MASK 8'h7F
`define INTC_PRIO_HIGH_MASK 8'h3F
`define INTC_WDT_SELECT_BIT 6

// Watchdog and flag register fields
`define INTC_WDI_XFER_FLAG 0
`define INTC_WDI_RTC_FLAG 1
`define INTC_WDI_XFER_EN 2
`define INTC_WDI_RTC_EN 3
`define INTC_WDI_MASK 8'h0F

// Reset values
`define INTC_RESET_BYTE 8'h00

// Edge sense per capture bit: ext0..ext5, xfer, rtc, ext6 combine
`define INTC_RISING_MASK 9'h1D3

// Vectors in polling order
`define INTC_VEC_EXT0 16'h0003
`define INTC_VEC_SER1 16'h0083
`define INTC_VEC_TMR0 16'h000B
`define INTC_VEC_EXT2 16'h004B
`define INTC_VEC_EXT1 16'h0013
`define INTC_VEC_EXT3 16'h0053
`define INTC_VEC_TMR1 16'h001B
`define INTC_VEC_EXT4 16'h005B
`define INTC_VEC_SER0 16'h0023
`define INTC_VEC_EXT5 16'h0063
`define INTC_VEC_EXT6 16'h006B

// Response timing in machine cycles (one core clock each)
`define INTC_DETECT_CYCLES 1
`define INTC_LCALL_CYCLES 6

`endif

/* rtl/intc_pkg.sv */
// Types shared by the interrupt controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package intc_pkg;
	typedef logic [1:0] level_type;
	typedef logic [3:0] src_index_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DETECT = 3'b010,
		ST_CALL = 3'b100
	} state_type;
endpackage : intc_pkg
`default_nettype wire

/* rtl/edge_capture.sv */
// Per-bit edge detector with a selectable sense per bit.
// Assumes inputs already on core_clk; the first cycle after reset is ignored.
`default_nettype none
module edge_capture #(
	parameter int WIDTH = 9,
	parameter logic [WIDTH-1:0] RISING = '1
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] pulse
);
	logic [WIDTH-1:0] prev_r;
	logic primed_r;

	initial begin
		if (WIDTH < 1) $error("edge_capture: WIDTH must be positive");
	end

	// A source already asserted at reset release must not fire
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_r <= '0;
			primed_r <= 1'b0;
		end else begin
			prev_r <= level;
			primed_r <= 1'b1;
		end
	end

	genvar i;
	for (i = 0; i < WIDTH; i++) begin : g_bit
		assign pulse[i] = primed_r & (RISING[i] ? (level[i] & ~prev_r[i])
			: (~level[i] & prev_r[i]));
	end
endmodule : edge_capture
`default_nettype wire

/* rtl/priority_resolver.sv */
// Picks the highest-level pending request, ties broken by polling order.
// Assumes index i belongs to group i/2 (pairs in polling order).
`default_nettype none
module priority_resolver
	import intc_pkg::*;
#(
	parameter int NUM_SRC = 11,
	parameter int NUM_GROUPS = 6
) (
	input wire logic [NUM_SRC-1:0] pending,
	input wire logic [2*NUM_GROUPS-1:0] groupLevel,
	output logic winValid,
	output intc_pkg::src_index_type winIndex,
	output intc_pkg::level_type winLevel
);
	initial begin
		if (NUM_SRC != 2 * NUM_GROUPS - 1)
			$error("priority_resolver: NUM_SRC must be 2*NUM_GROUPS-1");
		if (NUM_SRC > 16) $error("priority_resolver: index too narrow");
	end

	always_comb begin
		level_type lvl;
		lvl = 2'h0;
		winValid = 1'b0;
		winIndex = 4'h0;
		winLevel = 2'h0;
		// Walk backwards so the earliest poll position wins a tie
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			lvl = groupLevel[2*(i/2) +: 2];
			if (pending[i] && (!winValid || lvl >= winLevel)) begin
				winValid = 1'b1;
				winIndex = 4'(i);
				winLevel = lvl;
			end
		end
	end
endmodule : priority_resolver
`default_nettype wire

/* rtl/prioritized_interrupt_controller.sv */
// Interrupt priority, vectoring and external-flag logic for the core.
// Assumes sources and core handshakes run on core_clk; one machine
// cycle equals one core clock.
//
// Overview of operation
// - Sources form six groups of pairs in polling order; group 5 is ext 6.
// - Each group level is high bit and low bit; 00 lowest, 11 highest.
// - Ties at one level resolve in the fixed polling order.
// - Each source vectors to its fixed address.
// - Ext 0..6, transfer-done and one-second each have their own enable.
// - Flags set by hardware; ext 0..5 flags clear on service entry.
// - Transfer-done and one-second OR onto ext 6; software clears flags.
// - Both source flags live in the SFR at address E8.
// - Emulator reset leaves the transfer-done flag untouched.
// - Low priority bits 5..0 are groups; bit 6 watchdog only; bit 7 unused.
// - An active routine is preempted only by a strictly higher level.
// - Acknowledge only if nothing of equal or higher level is in service.
// - Response takes at least seven cycles: detect one, call six.
// - Ext 6 fires on an edge of its OR; uncleared flags block new edges.
`include "intc_consts.svh"
`default_nettype none
module prioritized_interrupt_controller
	import intc_pkg::*;
#(
	parameter int NUM_GROUPS = 6
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrWrEn,
	input wire logic sfrRdEn,
	output logic [7:0] sfrRdData,
	input wire logic [5:0] extSource,
	input wire logic transferDoneSource,
	input wire logic oneSecondSource,
	input wire logic timer0OverflowFlag,
	input wire logic timer1OverflowFlag,
	input wire logic serial0RxTxFlags,
	input wire logic serial1RxTxFlags,
	input wire logic instrInProgress,
	input wire logic retiExec,
	input wire logic emulatorReset,
	output logic lcallActive,
	output logic [15:0] intVector,
	output logic serviceEntry,
	output logic timer0Ack,
	output logic timer1Ack,
	output logic [3:0] inService
);
	localparam int NUM_SRC = 2 * NUM_GROUPS - 1;

	initial begin
		if (NUM_GROUPS != 6) $error("controller: six groups are wired");
	end

	// Vector table in polling order
	localparam logic [15:0] VECTORS [NUM_SRC] = '{
		`INTC_VEC_EXT0, `INTC_VEC_SER1, `INTC_VEC_TMR0, `INTC_VEC_EXT2,
		`INTC_VEC_EXT1, `INTC_VEC_EXT3, `INTC_VEC_TMR1, `INTC_VEC_EXT4,
		`INTC_VEC_SER0, `INTC_VEC_EXT5, `INTC_VEC_EXT6
	};

	logic [7:0] ien0_r;
	logic [7:0] ien1_r;
	logic [7:0] ien2_r;
	logic [7:0] prioLow_r;
	logic [7:0] prioHigh_r;
	logic [6:0] extFlag_r;
	logic [6:0] extFlag_nxt;
	logic transferDoneFlag_r;
	logic oneSecondFlag_r;
	logic transferDoneEnable_r;
	logic oneSecondEnable_r;
	logic [3:0] svc_r;
	logic [3:0] svc_nxt;
	state_type state_r;
	logic [2:0] callCount_r;
	src_index_type winIdx_r;
	level_type winLvl_r;

	logic [8:0] edgeLevel;
	logic [8:0] edgePulse;
	logic ext6Combined;
	logic [NUM_SRC-1:0] pending;
	logic [2*NUM_GROUPS-1:0] groupLevel;
	logic winValid;
	src_index_type winIndex;
	level_type winLevel;
	logic svcAny;
	level_type svcTop;
	logic allowed;
	logic ctrlWrite;
	logic takeRequest;
	logic enterService;

	// SFR write decode
	logic wrIen0;
	logic wrIen1;
	logic wrIen2;
	logic wrPrioLow;
	logic wrPrioHigh;
	logic wrExtFlags;
	logic wrWdi;

	assign wrIen0 = sfrWrEn && sfrAddr == `INTC_ADDR_IEN0;
	assign wrIen1 = sfrWrEn && sfrAddr == `INTC_ADDR_IEN1;
	assign wrIen2 = sfrWrEn && sfrAddr == `INTC_ADDR_IEN2;
	assign wrPrioLow = sfrWrEn && sfrAddr == `INTC_ADDR_PRIO_LOW;
	assign wrPrioHigh = sfrWrEn && sfrAddr == `INTC_ADDR_PRIO_HIGH;
	assign wrExtFlags = sfrWrEn && sfrAddr == `INTC_ADDR_EXT_FLAGS;
	assign wrWdi = sfrWrEn && sfrAddr == `INTC_ADDR_WDI;
	// Writes to enable or priority registers hold off an acknowledge
	assign ctrlWrite = wrIen0 | wrIen1 | wrIen2 | wrPrioLow | wrPrioHigh;

	// Enable and priority registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ien0_r <= `INTC_RESET_BYTE;
			ien1_r <= `INTC_RESET_BYTE;
			ien2_r <= `INTC_RESET_BYTE;
			prioLow_r <= `INTC_RESET_BYTE;
			prioHigh_r <= `INTC_RESET_BYTE;
		end else if (emulatorReset) begin
			ien0_r <= `INTC_RESET_BYTE;
			ien1_r <= `INTC_RESET_BYTE;
			ien2_r <= `INTC_RESET_BYTE;
			prioLow_r <= `INTC_RESET_BYTE;
			prioHigh_r <= `INTC_RESET_BYTE;
		end else begin
			if (wrIen0) ien0_r <= sfrWrData & `INTC_IEN0_MASK;
			if (wrIen1) ien1_r <= sfrWrData & `INTC_IEN1_MASK;
			if (wrIen2) ien2_r <= sfrWrData & `INTC_IEN2_MASK;
			// Bit 7 is dropped; bit 6 is stored but never steers priority
			if (wrPrioLow) prioLow_r <= sfrWrData & `INTC_PRIO_LOW_MASK;
			if (wrPrioHigh) prioHigh_r <= sfrWrData & `INTC_PRIO_HIGH_MASK;
		end
	end

	// Edge sources: ext0..5 with their own sense, the two ext6 sources,
	// and the gated OR that feeds ext6
	assign ext6Combined = (transferDoneFlag_r & transferDoneEnable_r)
		| (oneSecondFlag_r & oneSecondEnable_r);
	assign edgeLevel = {ext6Combined, oneSecondSource, transferDoneSource,
		extSource};

	edge_capture #(
		.WIDTH(9),
		.RISING(`INTC_RISING_MASK)
	) u_edges (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.level(edgeLevel),
		.pulse(edgePulse)
	);

	// Ext flags: set wins over both software clear and service entry
	always_comb begin
		extFlag_nxt = wrExtFlags ? sfrWrData[6:0] : extFlag_r;
		if (enterService) begin
			case (winIdx_r)
				4'h0: extFlag_nxt[0] = 1'b0;
				4'h3: extFlag_nxt[2] = 1'b0;
				4'h4: extFlag_nxt[1] = 1'b0;
				4'h5: extFlag_nxt[3] = 1'b0;
				4'h7: extFlag_nxt[4] = 1'b0;
				4'h9: extFlag_nxt[5] = 1'b0;
				default: ;
			endcase
		end
		// Ext6 only sees a new edge once its sources drop
		extFlag_nxt = extFlag_nxt | {edgePulse[8], edgePulse[5:0]};
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			extFlag_r <= 7'h00;
		end else if (emulatorReset) begin
			extFlag_r <= 7'h00;
		end else begin
			extFlag_r <= extFlag_nxt;
		end
	end

	// Source flags and enables in the watchdog and flag register
	// Hardware clears only the one-second flag, on emulator reset; otherwise software writes zero
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			transferDoneFlag_r <= 1'b0;
			oneSecondFlag_r <= 1'b0;
			transferDoneEnable_r <= 1'b0;
			oneSecondEnable_r <= 1'b0;
		end else begin
			if (edgePulse[6])
				transferDoneFlag_r <= 1'b1;
			else if (wrWdi)
				transferDoneFlag_r <= sfrWrData[`INTC_WDI_XFER_FLAG];
			// Emulator reset spares transfer-done; the engine runs on
			if (edgePulse[7])
				oneSecondFlag_r <= 1'b1;
			else if (emulatorReset)
				oneSecondFlag_r <= 1'b0;
			else if (wrWdi)
				oneSecondFlag_r <= sfrWrData[`INTC_WDI_RTC_FLAG];
			if (emulatorReset) begin
				transferDoneEnable_r <= 1'b0;
				oneSecondEnable_r <= 1'b0;
			end else if (wrWdi) begin
				transferDoneEnable_r <= sfrWrData[`INTC_WDI_XFER_EN];
				oneSecondEnable_r <= sfrWrData[`INTC_WDI_RTC_EN];
			end
		end
	end

	// Pending requests in polling order, gated by enables
	always_comb begin
		pending = '0;
		if (ien0_r[`INTC_IEN0_GLOBAL]) begin
			pending[0] = extFlag_r[0] & ien0_r[`INTC_IEN0_EXT0];
			pending[1] = serial1RxTxFlags & ien2_r[`INTC_IEN2_SER1];
			pending[2] = timer0OverflowFlag & ien0_r[`INTC_IEN0_TMR0];
			pending[3] = extFlag_r[2] & ien1_r[`INTC_IEN1_EXT2];
			pending[4] = extFlag_r[1] & ien0_r[`INTC_IEN0_EXT1];
			pending[5] = extFlag_r[3] & ien1_r[`INTC_IEN1_EXT2 + 1];
			pending[6] = timer1OverflowFlag & ien0_r[`INTC_IEN0_TMR1];
			pending[7] = extFlag_r[4] & ien1_r[`INTC_IEN1_EXT2 + 2];
			pending[8] = serial0RxTxFlags & ien0_r[`INTC_IEN0_SER0];
			pending[9] = extFlag_r[5] & ien1_r[`INTC_IEN1_EXT2 + 3];
			pending[10] = extFlag_r[6] & ien1_r[`INTC_IEN1_EXT2 + 4];
		end
	end

	// Level per group: high bit over low bit
	genvar g;
	for (g = 0; g < NUM_GROUPS; g++) begin : g_level
		assign groupLevel[2*g +: 2] = {prioHigh_r[g], prioLow_r[g]};
	end

	priority_resolver #(
		.NUM_SRC(NUM_SRC),
		.NUM_GROUPS(NUM_GROUPS)
	) u_resolver (
		.pending(pending),
		.groupLevel(groupLevel),
		.winValid(winValid),
		.winIndex(winIndex),
		.winLevel(winLevel)
	);

	// Highest level currently in service
	always_comb begin
		svcAny = |svc_r;
		svcTop = 2'h0;
		for (int l = 0; l < 4; l++) begin
			if (svc_r[l]) svcTop = 2'(l);
		end
	end

	assign allowed = !svcAny || winLevel > svcTop;
	assign takeRequest = state_r == ST_IDLE && winValid && allowed
		&& instrInProgress && !retiExec && !ctrlWrite;
	assign enterService = state_r == ST_DETECT;

	// Response sequence: one detect cycle, then the forced call
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_IDLE;
			callCount_r <= 3'h0;
			winIdx_r <= 4'h0;
			winLvl_r <= 2'h0;
		end else if (emulatorReset) begin
			state_r <= ST_IDLE;
			callCount_r <= 3'h0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (takeRequest) begin
						winIdx_r <= winIndex;
						winLvl_r <= winLevel;
						state_r <= ST_DETECT;
					end
				end
				ST_DETECT: begin
					callCount_r <= 3'(`INTC_LCALL_CYCLES - 1);
					state_r <= ST_CALL;
				end
				ST_CALL: begin
					if (callCount_r == 3'h0)
						state_r <= ST_IDLE;
					else
						callCount_r <= callCount_r - 3'h1;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// In-service levels: push on entry, pop the top on return
	always_comb begin
		svc_nxt = svc_r;
		if (retiExec && svcAny) svc_nxt[svcTop] = 1'b0;
		if (enterService) svc_nxt[winLvl_r] = 1'b1;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			svc_r <= 4'h0;
		end else if (emulatorReset) begin
			svc_r <= 4'h0;
		end else begin
			svc_r <= svc_nxt;
		end
	end

	// Core-facing outputs from flip-flops
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			intVector <= 16'h0000;
			timer0Ack <= 1'b0;
			timer1Ack <= 1'b0;
			serviceEntry <= 1'b0;
		end else begin
			if (enterService) intVector <= VECTORS[winIdx_r];
			timer0Ack <= enterService && winIdx_r == 4'h2;
			timer1Ack <= enterService && winIdx_r == 4'h6;
			serviceEntry <= state_r == ST_CALL && callCount_r == 3'h0;
		end
	end

	assign lcallActive = state_r == ST_CALL;
	assign inService = svc_r;

	// Register read port, one cycle latency; unmapped reads give zero
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sfrRdData <= 8'h00;
		end else if (sfrRdEn) begin
			case (sfrAddr)
				`INTC_ADDR_IEN0: sfrRdData <= ien0_r;
				`INTC_ADDR_IEN1: sfrRdData <= ien1_r;
				`INTC_ADDR_IEN2: sfrRdData <= ien2_r;
				`INTC_ADDR_PRIO_LOW: sfrRdData <= prioLow_r;
				`INTC_ADDR_PRIO_HIGH: sfrRdData <= prioHigh_r;
				`INTC_ADDR_EXT_FLAGS: sfrRdData <= {1'b0, extFlag_r};
				`INTC_ADDR_WDI: sfrRdData <= {4'h0, oneSecondEnable_r,
					transferDoneEnable_r, oneSecondFlag_r,
					transferDoneFlag_r};
				default: sfrRdData <= 8'h00;
			endcase
		end
	end
endmodule : prioritized_interrupt_controller
`default_nettype wire

/* verif/pic_checker_sva.sv */
// Checker for the interrupt controller: call timing, vectors, preemption.
// Assumes a bind onto the top module; one clock domain.
`default_nettype none
module pic_checker (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrRdEn,
	input wire logic [7:0] sfrRdData,
	input wire logic instrInProgress,
	input wire logic retiExec,
	input wire logic emulatorReset,
	input wire logic lcallActive,
	input wire logic [15:0] intVector,
	input wire logic serviceEntry,
	input wire logic timer0Ack,
	input wire logic timer1Ack,
	input wire logic [3:0] inService
);
	// Emulator reset may cut a call short, so it disables checks too
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n || emulatorReset);
	property p_call_len;
		$rose(lcallActive) |->
			lcallActive[*6] ##1 (!lcallActive && serviceEntry);
	endproperty
	property p_entry_once;
		serviceEntry |=> !serviceEntry;
	endproperty
	property p_taken;
		$rose(lcallActive) |->
			$past(instrInProgress, 2) && !$past(retiExec, 2);
	endproperty
	property p_vec;
		$rose(lcallActive) |-> intVector inside {16'h0003, 16'h000B,
			16'h0013, 16'h001B, 16'h0023, 16'h0083, 16'h004B, 16'h0053,
			16'h005B, 16'h0063, 16'h006B};
	endproperty
	property p_vec_hold;
		lcallActive && $past(lcallActive) |-> $stable(intVector);
	endproperty
	property p_t0;
		timer0Ack |-> $rose(lcallActive) && intVector == 16'h000B;
	endproperty
	property p_t1;
		timer1Ack |-> $rose(lcallActive) && intVector == 16'h001B;
	endproperty
	// The new level must sit above every level already in service
	property p_preempt;
		$rose(lcallActive) |-> $onehot(inService ^ $past(inService)) &&
			((inService ^ $past(inService)) > $past(inService));
	endproperty
	property p_prio_b7;
		sfrRdEn && sfrAddr == 8'hA9 |=> !sfrRdData[7];
	endproperty
	property p_wdi_hi;
		sfrRdEn && sfrAddr == 8'hE8 |=> sfrRdData[7:4] == 4'h0;
	endproperty
	a_call_len: assert property (p_call_len) else $error("call length");
	a_entry_once: assert property (p_entry_once) else $error("entry");
	a_taken: assert property (p_taken) else $error("bad accept");
	a_vec: assert property (p_vec) else $error("bad vector");
	a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
	a_t0: assert property (p_t0) else $error("timer 0 ack");
	a_t1: assert property (p_t1) else $error("timer 1 ack");
	a_preempt: assert property (p_preempt) else $error("preempt");
	a_prio_b7: assert property (p_prio_b7) else $error("bit 7 set");
	a_wdi_hi: assert property (p_wdi_hi) else $error("upper bits");
	c_t1: cover property (timer1Ack);
	c_preempt: cover property ($rose(lcallActive) && $past(inService) != 4'h0);
	c_reti: cover property (retiExec && inService != 4'h0);
endmodule : pic_checker
`default_nettype wire

/* verif/core_model.sv */
// Model of the core and the timer peripherals facing the controller.
// Assumes the bench asks for RETI only while no call is running.
`default_nettype none
module core_model (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic holdOff,
	input wire logic slow,
	input wire logic retiReq,
	input wire logic t0Set,
	input wire logic t1Set,
	input wire logic timer0Ack,
	input wire logic timer1Ack,
	output logic instrInProgress,
	output logic retiExec,
	output logic timer0OverflowFlag,
	output logic timer1OverflowFlag
);
	logic [1:0] phase_r;
	// Slow mode loses one cycle in four to mimic long instructions
	assign instrInProgress = !holdOff && !(slow && phase_r == 2'h3);
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_r <= 2'h0;
			retiExec <= 1'b0;
		end else begin
			phase_r <= phase_r + 2'h1;
			retiExec <= retiReq;
		end
	end
	// A timer flag stays up until its ack, so a lost ack shows as a repeat
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			timer0OverflowFlag <= 1'b0;
			timer1OverflowFlag <= 1'b0;
		end else begin
			timer0OverflowFlag <= t0Set || (timer0OverflowFlag && !timer0Ack);
			timer1OverflowFlag <= t1Set || (timer1OverflowFlag && !timer1Ack);
		end
	end
endmodule : core_model
`default_nettype wire

/* verif/prioritized_interrupt_controller_tb_top.sv */
// Bench for the interrupt controller: registers, masking, vectors, levels.
// Assumes the rtl folder on the include path.
`include "intc_consts.svh"
`default_nettype none
module prioritized_interrupt_controller_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] VEC [11] = '{16'h0003, 16'h0083, 16'h000B,
		16'h004B, 16'h0013, 16'h0053, 16'h001B, 16'h005B, 16'h0023,
		16'h0063, 16'h006B};
	localparam int EXT_BIT [11] = '{0, -1, -1, 2, 1, 3, -1, 4, -1, 5, -1};
	localparam logic [5:0] IDLE = 6'h2C;
	localparam logic [7:0] ADR [6] = '{`INTC_ADDR_IEN0, `INTC_ADDR_IEN1,
		`INTC_ADDR_IEN2, `INTC_ADDR_PRIO_LOW, `INTC_ADDR_PRIO_HIGH, 8'h55};
	localparam logic [7:0] MSK [6] = '{8'h9F, 8'h3E, 8'h01, 8'h7F, 8'h3F,
		8'h00};
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] sfrAddr = 8'h00;
	logic [7:0] sfrWrData = 8'h00;
	logic sfrWrEn = 1'b0;
	logic sfrRdEn = 1'b0;
	logic [5:0] extSource = IDLE;
	logic transferDoneSource = 1'b0;
	logic oneSecondSource = 1'b0;
	logic serial0RxTxFlags = 1'b0;
	logic serial1RxTxFlags = 1'b0;
	logic emulatorReset = 1'b0;
	logic holdOff = 1'b0;
	logic slow = 1'b0;
	logic retiReq = 1'b0;
	logic t0Set = 1'b0;
	logic t1Set = 1'b0;
	logic [7:0] sfrRdData;
	logic [15:0] intVector;
	logic [3:0] inService;
	logic instrInProgress, retiExec, lcallActive, serviceEntry;
	logic timer0OverflowFlag, timer1OverflowFlag, timer0Ack, timer1Ack;
	logic [7:0] prioLo = 8'h00;
	logic [7:0] prioHi = 8'h00;
	logic [31:0] seed = 32'h19;
	int nErrors = 0;
	int nTests = 0;
	int nEntry = 0;
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) if (serviceEntry === 1'b1) nEntry++;
	prioritized_interrupt_controller prioritized_interrupt_controller_i (
		.core_clk(core_clk), .arst_n(arst_n), .sfrAddr(sfrAddr),
		.sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
		.sfrRdData(sfrRdData), .extSource(extSource),
		.transferDoneSource(transferDoneSource),
		.oneSecondSource(oneSecondSource),
		.timer0OverflowFlag(timer0OverflowFlag),
		.timer1OverflowFlag(timer1OverflowFlag),
		.serial0RxTxFlags(serial0RxTxFlags),
		.serial1RxTxFlags(serial1RxTxFlags),
		.instrInProgress(instrInProgress), .retiExec(retiExec),
		.emulatorReset(emulatorReset), .lcallActive(lcallActive),
		.intVector(intVector), .serviceEntry(serviceEntry),
		.timer0Ack(timer0Ack), .timer1Ack(timer1Ack), .inService(inService));
	core_model core_model_i (.core_clk(core_clk), .arst_n(arst_n),
		.holdOff(holdOff), .slow(slow), .retiReq(retiReq), .t0Set(t0Set),
		.t1Set(t1Set), .timer0Ack(timer0Ack), .timer1Ack(timer1Ack),
		.instrInProgress(instrInProgress), .retiExec(retiExec),
		.timer0OverflowFlag(timer0OverflowFlag),
		.timer1OverflowFlag(timer1OverflowFlag));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [1:0] lvOf(input int i);
		return {prioHi[i / 2], prioLo[i / 2]};
	endfunction : lvOf
	// Highest level above cur wins; strict compare keeps polling order
	function automatic int best(input logic [10:0] p, input int cur);
		int b;
		b = -1;
		for (int i = 0; i < 11; i++)
			if (p[i] && int'(lvOf(i)) > cur && (b < 0 || lvOf(i) > lvOf(b)))
				b = i;
		return b;
	endfunction : best
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		nTests++;
		if (got !== exp) begin
			nErrors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWrEn <= 1'b1;
		@(posedge core_clk);
		sfrWrEn <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		sfrAddr <= a;
		sfrRdEn <= 1'b1;
		@(posedge core_clk);
		sfrRdEn <= 1'b0;
		#1;
		check({8'h00, sfrRdData}, {8'h00, e});
	endtask : rd
	task automatic fire(input logic [11:0] m);
		logic [5:0] e;
		e = IDLE;
		for (int i = 0; i < 10; i++)
			if (m[i] && EXT_BIT[i] >= 0) e[EXT_BIT[i]] = ~e[EXT_BIT[i]];
		@(posedge core_clk);
		extSource <= e;
		t0Set <= m[2];
		t1Set <= m[6];
		serial1RxTxFlags <= serial1RxTxFlags | m[1];
		serial0RxTxFlags <= serial0RxTxFlags | m[8];
		transferDoneSource <= m[10];
		oneSecondSource <= m[11];
		@(posedge core_clk);
		extSource <= IDLE;
		t0Set <= 1'b0;
		t1Set <= 1'b0;
		transferDoneSource <= 1'b0;
		oneSecondSource <= 1'b0;
		repeat (5) @(posedge core_clk);
	endtask : fire
	task automatic serve(input logic [10:0] m);
		int stk[$];
		int e;
		int w;
		logic [10:0] p;
		p = m;
		while (p != 11'h000 || stk.size() > 0) begin
			e = best(p, stk.size() > 0 ? stk[$] : -1);
			@(posedge core_clk);
			if (e < 0) begin
				retiReq <= 1'b1;
				@(posedge core_clk);
				retiReq <= 1'b0;
				void'(stk.pop_back());
			end else begin
				#1;
				for (w = 0; w < 300 && serviceEntry !== 1'b1; w++) begin
					@(posedge core_clk);
					#1;
				end
				check({15'h0000, serviceEntry}, 16'h0001);
				check(intVector, VEC[e]);
				p[e] = 1'b0;
				stk.push_back(int'(lvOf(e)));
				@(posedge core_clk);
				if (e == 1) serial1RxTxFlags <= 1'b0;
				if (e == 8) serial0RxTxFlags <= 1'b0;
				if (e == 10) begin
					wr(`INTC_ADDR_WDI, 8'h0C);
					wr(`INTC_ADDR_EXT_FLAGS, 8'h00);
				end
			end
		end
	endtask : serve
	task automatic round(input logic [7:0] lo, input logic [7:0] hi,
		input logic [11:0] m);
		prioLo = lo;
		prioHi = hi;
		wr(`INTC_ADDR_PRIO_LOW, lo);
		wr(`INTC_ADDR_PRIO_HIGH, hi);
		@(posedge core_clk);
		holdOff <= 1'b1;
		fire(m);
		holdOff <= 1'b0;
		serve(m[10:0]);
	endtask : round
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done
	initial begin
		int n;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(ADR[i], 8'h00);
			wr(ADR[i], 8'hFF);
			rd(ADR[i], MSK[i]);
			wr(ADR[i], 8'h00);
		end
		rd(`INTC_ADDR_WDI, 8'h00);
		wr(`INTC_ADDR_IEN0, 8'h9E);
		wr(`INTC_ADDR_IEN1, 8'h3E);
		wr(`INTC_ADDR_IEN2, 8'h01);
		wr(`INTC_ADDR_WDI, 8'h0C);
		n = nEntry;
		fire(12'h001);
		repeat (20) @(posedge core_clk);
		check(16'(nEntry - n), 16'h0000);
		rd(`INTC_ADDR_EXT_FLAGS, 8'h01);
		wr(`INTC_ADDR_IEN0, 8'h9F);
		serve(11'h001);
		rd(`INTC_ADDR_EXT_FLAGS, 8'h00);
		for (int i = 0; i < 11; i++) round(8'h00, 8'h00, 12'(1 << i));
		@(posedge core_clk);
		holdOff <= 1'b1;
		fire(12'h400);
		fire(12'h800);
		wr(`INTC_ADDR_EXT_FLAGS, 8'h00);
		rd(`INTC_ADDR_EXT_FLAGS, 8'h00);
		rd(`INTC_ADDR_WDI, 8'h0F);
		wr(`INTC_ADDR_WDI, 8'h0C);
		fire(12'h800);
		rd(`INTC_ADDR_EXT_FLAGS, 8'h40);
		wr(`INTC_ADDR_WDI, 8'h0C);
		wr(`INTC_ADDR_EXT_FLAGS, 8'h00);
		@(posedge core_clk);
		holdOff <= 1'b0;
		round(8'h00, 8'h00, 12'h3FF);
		round(8'h40, 8'h00, 12'h3FF);
		round(8'h07, 8'h38, 12'h3FF);
		round(8'h15, 8'h2A, 12'h3FF);
		repeat (12) begin
			seed = xs(seed);
			@(posedge core_clk);
			slow <= seed[31];
			round(seed[7:0], seed[15:8], {2'b00, seed[25:16]});
		end
		// Level 0 ext0 in service, equal ext1 waits, level 3 timer 0 preempts
		wr(`INTC_ADDR_PRIO_LOW, 8'h02);
		wr(`INTC_ADDR_PRIO_HIGH, 8'h02);
		fire(12'h011);
		repeat (10) @(posedge core_clk);
		#1;
		check(16'(inService), 16'h0001);
		check(intVector, 16'h0003);
		fire(12'h004);
		repeat (10) @(posedge core_clk);
		#1;
		check(16'(inService), 16'h0009);
		check(intVector, 16'h000B);
		check({15'h0000, timer0OverflowFlag}, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk);
			retiReq <= 1'b1;
			@(posedge core_clk);
			retiReq <= 1'b0;
			repeat (12) @(posedge core_clk);
			#1;
			check(intVector, i == 0 ? 16'h000B : 16'h0013);
			check(16'(inService), i == 2 ? 16'h0000 : 16'h0001);
		end
		@(posedge core_clk);
		holdOff <= 1'b1;
		fire(12'hC00);
		@(posedge core_clk);
		emulatorReset <= 1'b1;
		@(posedge core_clk);
		emulatorReset <= 1'b0;
		rd(`INTC_ADDR_WDI, 8'h01);
		rd(`INTC_ADDR_IEN0, 8'h00);
		test_done();
	end
	// Whole run needs about 2000 cycles; the limit of 40000 allows twenty times that
	initial begin
		repeat (40000) @(posedge core_clk);
		nErrors++;
		test_done();
	end
endmodule : prioritized_interrupt_controller_tb_top
bind prioritized_interrupt_controller pic_checker pic_checker_i (
	.core_clk(core_clk), .arst_n(arst_n), .sfrAddr(sfrAddr),
	.sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
	.instrInProgress(instrInProgress), .retiExec(retiExec),
	.emulatorReset(emulatorReset), .lcallActive(lcallActive),
	.intVector(intVector), .serviceEntry(serviceEntry),
	.timer0Ack(timer0Ack), .timer1Ack(timer1Ack), .inService(inService));
`default_nettype wire
